// >>> ntc_pkg.sv
// Behaviour
// - Frame delay compensation shortens card-emulation frame delay by value times one carrier period.
// - Zero compensation gives nominal frame delay; nonzero shortens it.
// - Passive target bit 3 disables active peer-to-peer frame recognition when set.
// - Passive target bit 2 disables automatic 212/424 SENSF_RES responses when set.
// - Passive target bit 0 disables automatic NFC-A anti-collision when set.
// - With both bit 2 and bit 0 set, target traffic goes only through FIFO.
// - Sub-carrier frequency code 01 gives fc/32, code 00 gives fc/16 BPSK.
// - Pulse count code 10 gives 4, code 11 gives 8 pulses; others reserved.
// - Transmit period codes 0..3 give fc/128, fc/64, fc/32, fc/16; top bit reserved.
// - Auxiliary bit 7 set disables receive CRC check for all protocols.
// - CRC check skipped after REQA/WUPA commands and during anti-collision.
// - Identifier size code 00 selects 4 bytes, 01 selects 7 bytes.
// - Phase clock bit selects unshifted or 90 degree shifted measurement clock.
// - Receiver mode bit clear selects correlation receive; set is reserved.
// - Two-bit field n value feeds the field-on direct commands.
// - Registers 08h, 09h, 0Ah are read/write and reset to zero.
package ntc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] PTD_IDX = 8'h08;
  localparam logic [7:0] SMD_IDX = 8'h09;
  localparam logic [7:0] AUX_IDX = 8'h0a;
  localparam logic [7:0] RST_VAL = 8'h00;
  // Writable bits; zeros are reserved positions
  localparam logic [7:0] PTD_MASK = 8'hfd;
  localparam logic [7:0] SMD_MASK = 8'h7f;
  localparam logic [7:0] AUX_MASK = 8'hbf;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FDEL_LSB = 4;
  localparam int P2P_BIT = 3;
  localparam int FRESP_BIT = 2;
  localparam int ACOL_BIT = 0;
  localparam int SCF_LSB = 5;
  localparam int SCP_LSB = 3;
  localparam int STX_LSB = 0;
  localparam int NOCRC_BIT = 7;
  localparam int IDSZ_LSB = 4;
  localparam int PHCLK_BIT = 3;
  localparam int RXMODE_BIT = 2;
  localparam int NVAL_LSB = 0;
  // ----------------------------------------
  // Decoded values
  // ----------------------------------------
  localparam logic [3:0] PULSES_4 = 4'h4;
  localparam logic [3:0] PULSES_8 = 4'h8;
  localparam logic [7:0] DIV_128 = 8'h80;
  localparam logic [7:0] DIV_64 = 8'h40;
  localparam logic [7:0] DIV_32 = 8'h20;
  localparam logic [7:0] DIV_16 = 8'h10;
  localparam logic [2:0] ID_BYTES_4 = 3'h4;
  localparam logic [2:0] ID_BYTES_7 = 3'h7;
  typedef struct packed {
    logic [7:0] ptd;
    logic [7:0] smd;
    logic [7:0] aux;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] fdt_trim;
    logic p2p_off;
    logic felresp_off;
    logic anticoll_off;
    logic fifo_only;
    logic [7:0] sc_div;
    logic sc_valid;
    logic [3:0] pulses;
    logic pulses_valid;
    logic [7:0] tx_div;
    logic tx_valid;
    logic crc_check;
    logic [2:0] id_bytes;
    logic id_valid;
    logic phase_shift;
    logic rx_corr;
    logic [1:0] field_n;
  } ntc_state_s;
endpackage

// >>> ntc_regs.sv
`timescale 1ns/1ns
module ntc_regs (
  input wire logic pclk, // 250 MHz clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic crc_bypass_req, // Engine: REQA/WUPA sent or anti-collision active
  output logic [3:0] fdt_trim, // Carrier periods removed from frame delay
  output logic p2p_off, // Active peer-to-peer recognition disabled
  output logic felresp_off, // Automatic 212/424 responses disabled
  output logic anticoll_off, // Automatic NFC-A anti-collision disabled
  output logic fifo_only, // Target traffic only via FIFO
  output logic [7:0] sc_div, // Sub-carrier divider of fc
  output logic sc_valid, // Sub-carrier code is defined
  output logic [3:0] pulses, // Sub-carrier pulses per report
  output logic pulses_valid, // Pulse code is defined
  output logic [7:0] tx_div, // Modulator period divider of fc
  output logic tx_valid, // Period code is defined
  output logic crc_check, // Check receive CRC now
  output logic [2:0] id_bytes, // Identifier length in bytes
  output logic id_valid, // Identifier code is defined
  output logic phase_shift, // Use 90 degree phase clock
  output logic rx_corr, // Correlation receiver selected
  output logic [1:0] field_n // Parameter n for field-on commands
);
  ntc_pkg::ntc_state_s st_r;
  ntc_pkg::ntc_state_s st_nxt;
  logic [7:0] idx;
  logic hit;
  logic acc;

  // ----------------------------------------
  // Bus decode and register update
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    idx = paddr[9:2];
    hit = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0) &&
          (idx == ntc_pkg::PTD_IDX || idx == ntc_pkg::SMD_IDX || idx == ntc_pkg::AUX_IDX);
    // One wait state: ready rises on the second access cycle, drops after
    acc = psel && penable && !st_r.pready;
    st_nxt.pready = acc;
    st_nxt.pslverr = acc && !hit;
    if (acc && pwrite && hit && pstrb[0]) begin
      case (idx)
        ntc_pkg::PTD_IDX: st_nxt.ptd = pwdata[7:0] & ntc_pkg::PTD_MASK;
        ntc_pkg::SMD_IDX: st_nxt.smd = pwdata[7:0] & ntc_pkg::SMD_MASK;
        ntc_pkg::AUX_IDX: st_nxt.aux = pwdata[7:0] & ntc_pkg::AUX_MASK;
        default: st_nxt.ptd = st_r.ptd;
      endcase
    end
    st_nxt.prdata = 32'h0;
    if (acc && !pwrite && hit) begin
      case (idx)
        ntc_pkg::PTD_IDX: st_nxt.prdata = {24'h0, st_r.ptd};
        ntc_pkg::SMD_IDX: st_nxt.prdata = {24'h0, st_r.smd};
        ntc_pkg::AUX_IDX: st_nxt.prdata = {24'h0, st_r.aux};
        default: st_nxt.prdata = 32'h0;
      endcase
    end

    // ----------------------------------------
    // Field decode from the next register image
    // ----------------------------------------
    // Zero gives the nominal delay; the engine subtracts this many fc periods
    st_nxt.fdt_trim = st_nxt.ptd[ntc_pkg::FDEL_LSB +: 4];
    st_nxt.p2p_off = st_nxt.ptd[ntc_pkg::P2P_BIT];
    st_nxt.felresp_off = st_nxt.ptd[ntc_pkg::FRESP_BIT];
    st_nxt.anticoll_off = st_nxt.ptd[ntc_pkg::ACOL_BIT];
    st_nxt.fifo_only = st_nxt.ptd[ntc_pkg::FRESP_BIT] && st_nxt.ptd[ntc_pkg::ACOL_BIT];
    case (st_nxt.smd[ntc_pkg::SCF_LSB +: 2])
      2'h0: begin
        st_nxt.sc_div = ntc_pkg::DIV_16;
        st_nxt.sc_valid = 1'b1;
      end
      2'h1: begin
        st_nxt.sc_div = ntc_pkg::DIV_32;
        st_nxt.sc_valid = 1'b1;
      end
      default: begin
        st_nxt.sc_div = 8'h0;
        st_nxt.sc_valid = 1'b0;
      end
    endcase
    case (st_nxt.smd[ntc_pkg::SCP_LSB +: 2])
      2'h2: begin
        st_nxt.pulses = ntc_pkg::PULSES_4;
        st_nxt.pulses_valid = 1'b1;
      end
      2'h3: begin
        st_nxt.pulses = ntc_pkg::PULSES_8;
        st_nxt.pulses_valid = 1'b1;
      end
      default: begin
        st_nxt.pulses = 4'h0;
        st_nxt.pulses_valid = 1'b0;
      end
    endcase
    st_nxt.tx_valid = !st_nxt.smd[ntc_pkg::STX_LSB + 2];
    case (st_nxt.smd[ntc_pkg::STX_LSB +: 2])
      2'h0: st_nxt.tx_div = ntc_pkg::DIV_128;
      2'h1: st_nxt.tx_div = ntc_pkg::DIV_64;
      2'h2: st_nxt.tx_div = ntc_pkg::DIV_32;
      default: st_nxt.tx_div = ntc_pkg::DIV_16;
    endcase
    if (!st_nxt.tx_valid) begin
      st_nxt.tx_div = 8'h0;
    end
    // Bypass request from the engine overrides the software enable
    st_nxt.crc_check = !st_nxt.aux[ntc_pkg::NOCRC_BIT] && !crc_bypass_req;
    case (st_nxt.aux[ntc_pkg::IDSZ_LSB +: 2])
      2'h0: begin
        st_nxt.id_bytes = ntc_pkg::ID_BYTES_4;
        st_nxt.id_valid = 1'b1;
      end
      2'h1: begin
        st_nxt.id_bytes = ntc_pkg::ID_BYTES_7;
        st_nxt.id_valid = 1'b1;
      end
      default: begin
        st_nxt.id_bytes = 3'h0;
        st_nxt.id_valid = 1'b0;
      end
    endcase
    st_nxt.phase_shift = st_nxt.aux[ntc_pkg::PHCLK_BIT];
    st_nxt.rx_corr = !st_nxt.aux[ntc_pkg::RXMODE_BIT];
    st_nxt.field_n = st_nxt.aux[ntc_pkg::NVAL_LSB +: 2];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.ptd <= ntc_pkg::RST_VAL;
      st_r.smd <= ntc_pkg::RST_VAL;
      st_r.aux <= ntc_pkg::RST_VAL;
      st_r.crc_check <= 1'b1;
      st_r.rx_corr <= 1'b1;
      st_r.sc_div <= ntc_pkg::DIV_16;
      st_r.sc_valid <= 1'b1;
      st_r.tx_div <= ntc_pkg::DIV_128;
      st_r.tx_valid <= 1'b1;
      st_r.id_bytes <= ntc_pkg::ID_BYTES_4;
      st_r.id_valid <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign fdt_trim = st_r.fdt_trim;
  assign p2p_off = st_r.p2p_off;
  assign felresp_off = st_r.felresp_off;
  assign anticoll_off = st_r.anticoll_off;
  assign fifo_only = st_r.fifo_only;
  assign sc_div = st_r.sc_div;
  assign sc_valid = st_r.sc_valid;
  assign pulses = st_r.pulses;
  assign pulses_valid = st_r.pulses_valid;
  assign tx_div = st_r.tx_div;
  assign tx_valid = st_r.tx_valid;
  assign crc_check = st_r.crc_check;
  assign id_bytes = st_r.id_bytes;
  assign id_valid = st_r.id_valid;
  assign phase_shift = st_r.phase_shift;
  assign rx_corr = st_r.rx_corr;
  assign field_n = st_r.field_n;
endmodule

// >>> ntc_regs_checker.sv
`timescale 1ns/1ns
module ntc_regs_checker (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic crc_bypass_req, // Engine bypass
  input wire logic crc_check, // CRC on
  input wire logic [3:0] fdt_trim, // Delay trim
  input wire logic felresp_off, // Auto resp off
  input wire logic anticoll_off, // Anticoll off
  input wire logic fifo_only, // FIFO path
  input wire logic [7:0] sc_div, // Sub-carrier
  input wire logic sc_valid // Code defined
);
  // --------------------------------
  // Port relations
  // --------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no ready after one wait");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_fifo; fifo_only == (felresp_off && anticoll_off); endproperty
  a_fifo: assert property (p_fifo) else $error("fifo path wrong");
  property p_crc; $past(crc_bypass_req) |-> !crc_check; endproperty
  a_crc: assert property (p_crc) else $error("crc not bypassed");
  property p_sc; sc_valid ? sc_div inside {8'h10, 8'h20} : sc_div == 8'h0; endproperty
  a_sc: assert property (p_sc) else $error("sub-carrier decode");
  property p_hold; !(psel && penable && pwrite && !pready) |=> $stable(fdt_trim); endproperty
  a_hold: assert property (p_hold) else $error("trim moved");
endmodule
bind ntc_regs ntc_regs_checker u_chk (.*);

// >>> ntc_regs_tb.sv
`timescale 1ns/1ns
module ntc_regs_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, crc_bypass_req = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic [3:0] pstrb = 0, fdt_trim, pulses;
  logic pready, pslverr, p2p_off, felresp_off, anticoll_off, fifo_only, sc_valid;
  logic pulses_valid, tx_valid, crc_check, id_valid, phase_shift, rx_corr;
  logic [7:0] sc_div, tx_div;
  logic [2:0] id_bytes;
  logic [1:0] field_n;
  logic [32:0] q[$];
  logic [7:0] msk[3] = '{ntc_pkg::PTD_MASK, ntc_pkg::SMD_MASK, ntc_pkg::AUX_MASK};
  int num_errors = 0, comparisons = 0;
  ntc_regs dut (.*);
  initial forever #2 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d, input logic [3:0] s,
                     input logic [32:0] e);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    q.push_back(e);
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      num_errors++;
      conclude();
    end
    psel <= 0;
    penable <= 0;
    // Idle edge keeps two drives of psel out of one time step
    @(posedge pclk);
  endtask
  always @(posedge pclk) if (pready === 1'b1) begin
    logic [32:0] e;
    e = q.pop_front();
    chk({31'h0, pslverr}, {31'h0, e[32]});
    if (!pwrite) chk(prdata, e[31:0]);
  end
  task automatic outs(input logic [7:0] v, input logic b);
    chk(fdt_trim, v[7:4]);
    chk({p2p_off, felresp_off, anticoll_off, fifo_only}, {v[3], v[2], v[0], v[2] & v[0]});
    chk({sc_valid, sc_div}, v[6:5] == 0 ? 9'h110 : v[6:5] == 1 ? 9'h120 : 9'h0);
    chk({pulses_valid, pulses}, v[4] ? {1'b1, v[3] ? 4'h8 : 4'h4} : 5'h0);
    chk({tx_valid, tx_div}, v[2] ? 9'h0 : {1'b1, 8'h80 >> v[1:0]});
    chk(crc_check, !v[7] && !b);
    chk({id_valid, id_bytes}, v[5] ? 4'h0 : v[4] ? 4'hf : 4'hc);
    chk({phase_shift, rx_corr, field_n}, {v[3], !v[2], v[1:0]});
  endtask
  // --------------------------------
  // Stimulus
  // --------------------------------
  initial begin
    logic [7:0] v;
    logic b;
    void'($urandom(92952));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    outs(8'h0, 1'b0);
    for (int r = 0; r < 3; r++) apb(0, 32'h20 + 4 * r, 0, 4'h0, 33'h0);
    for (int i = 0; i < 256; i++) begin
      v = i[7:0];
      b = 1'($urandom);
      crc_bypass_req <= b;
      for (int r = 0; r < 3; r++) apb(1, 32'h20 + 4 * r, {24'($urandom), v}, 4'($urandom) | 4'h1, 33'h0);
      for (int r = 0; r < 3; r++) apb(0, 32'h20 + 4 * r, 0, 4'h0, {25'h0, v & msk[r]});
      outs(v, b);
    end
    apb(1, 32'h2c, 32'hff, 4'hf, {1'b1, 32'h0});
    apb(0, 32'h21, 0, 4'h0, {1'b1, 32'h0});
    apb(1, 32'h20, 32'h0, 4'he, 33'h0);
    apb(0, 32'h20, 0, 4'h0, {25'h0, msk[0]});
    apb(1, 32'h20, 32'h20, 4'h1, 33'h0);
    apb(1, 32'h28, 32'h01, 4'h1, 33'h0);
    chk(fdt_trim, 4'h2);
    chk({phase_shift, field_n}, 3'h1);
    chk(q.size(), 0);
    conclude();
  end
endmodule
